// ===== verif/lane_alarm_offset_trim_regs_bench.sv
// Self-checking bench for the lane alarm and offset trim register slice
`timescale 1ns/10ps
module lane_alarm_offset_trim_regs_bench;
  logic clk, rstn, reg_wr, reg_rd, link, busy, fg, sel, ok;
  logic os_en, bg_en, bgos_en, irq;
  logic [11:0] reg_addr, f0, f1, f2a, f2b, c0, c1, c2;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] err;
  int fails, compares;

  lane_alarm_offset_trim_regs i_lane_alarm_offset_trim_regs (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_fifo_error(err), .serial_link_enable(link),
    .fuse_core0(f0), .fuse_core1(f1), .fuse_core2_a(f2a), .fuse_core2_b(f2b),
    .offset_cal_busy(busy), .foreground_complete_flag(fg), .core2_on_second_input(sel),
    .core0_offset_value(c0), .core1_offset_value(c1), .core2_offset_value(c2),
    .offset_calibration_enable(os_en), .background_calibration_enable(bg_en),
    .continuous_background_offset_enable(bgos_en), .irq(irq));

  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_check(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, e);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    err <= m;
    @(posedge clk);
    err <= 8'h00;
  endtask

  // Lets registered outputs and the select path land
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    {rstn, reg_wr, reg_rd, busy, fg, sel, err, reg_addr, reg_wdata} = '0;
    link = 1'b1;
    f0 = 12'hA51;
    f1 = 12'h3C7;
    f2a = 12'h0F2;
    f2b = 12'h90E;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    rd_check(12'h2C4, 16'h00FF);
    rd_check(12'h2C0, 16'h0020);
    rd_check(12'h330, {4'h0, f0});
    check({4'h0, c1}, {4'h0, f1});
    check({4'h0, c2}, {4'h0, f2a});
    @(posedge clk);
    sel <= 1'b1;
    settle;
    check({4'h0, c2}, {4'h0, f2b});
    $display("reset test done");
    wr(12'h2C4, 16'h00FF);
    wr(12'h2C0, 16'h0020);
    rd_check(12'h2C4, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      rd_check(12'h2C4, 16'h0001 << i);
      wr(12'h2C4, 16'h0001 << i);
    end
    rd_check(12'h2C0, 16'h0020);
    @(posedge clk);
    err <= 8'h81;
    wr(12'h2C4, 16'h00FF);
    rd_check(12'h2C4, 16'h0081);
    @(posedge clk);
    err <= 8'h00;
    wr(12'h2C0, 16'h0020);
    rd_check(12'h2C4, 16'h0000);
    rd_check(12'h2C0, 16'h0000);
    wr(12'h2C2, 16'h0000);
    pulse(8'h04);
    settle;
    check({15'h0, irq}, 16'h0001);
    wr(12'h2C2, 16'h0020);
    settle;
    check({15'h0, irq}, 16'h0000);
    wr(12'h2C2, 16'h0000);
    wr(12'h2C0, 16'h0020);
    settle;
    check({15'h0, irq}, 16'h0000);
    // Errors while the link is off must leave the flags alone
    @(posedge clk);
    link <= 1'b0;
    pulse(8'hFF);
    rd_check(12'h2C4, 16'h0000);
    rd_check(12'h2C0, 16'h0000);
    @(posedge clk);
    link <= 1'b1;
    $display("alarm test done");
    // First-input trim is written while core 2 samples that input
    @(posedge clk);
    sel <= 1'b0;
    wr(12'h330, 16'h0FFF);
    wr(12'h332, 16'h0000);
    wr(12'h334, 16'h0801);
    repeat (3) @(posedge clk);
    sel <= 1'b1;
    wr(12'h336, 16'h07FE);
    wr(12'h100, 16'hFFFF);
    rd_check(12'h334, 16'h0801);
    rd_check(12'h336, 16'h07FE);
    rd_check(12'h100, 16'h0000);
    check({4'h0, c0}, 16'h0FFF);
    check({4'h0, c1}, 16'h0000);
    check({4'h0, c2}, 16'h07FE);
    @(posedge clk);
    sel <= 1'b0;
    settle;
    check({4'h0, c2}, 16'h0801);
    $display("trim test done");
    for (int k = 0; k < 32; k++)
    begin
      wr(12'h340, {13'h0, k[2:0]});
      busy <= k[3];
      fg <= k[4];
      settle;
      check({13'h0, bgos_en, bg_en, os_en}, {13'h0, k[2:0]});
      ok = !k[3] && !(k[1] && k[2]) && (!k[0] || k[4]);
      rd_check(12'h342, {14'h0, ok, k[4]});
    end
    $display("access status test done");
    tally_and_finish;
  end

  // Watchdog well beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
endmodule

// ===== verif/lane_alarm_offset_trim_regs_properties.sv
// Port-level assertions for the lane alarm and offset trim register slice
`timescale 1ns/10ps
module lane_alarm_offset_trim_regs_properties #(
  parameter int LANES = 8,
  parameter int TRIM_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Lane events, fuse and input select
  input wire logic [LANES-1:0] lane_fifo_error,
  input wire logic serial_link_enable,
  input wire logic [TRIM_W-1:0] fuse_core0,
  input wire logic core2_on_second_input,
  // Core trims, control and interrupt
  input wire logic [TRIM_W-1:0] core0_offset_value,
  input wire logic [TRIM_W-1:0] core1_offset_value,
  input wire logic [TRIM_W-1:0] core2_offset_value,
  input wire logic offset_calibration_enable,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Read data only in the cycle after a read strobe
  a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  // A lane event two edges back must show in the flags read
  a_lane_flag_set: assert property (reg_rd && reg_addr == 12'h2C4
    && $past(serial_link_enable)
    |=> (reg_rdata[7:0] & $past(lane_fifo_error, 2)) == $past(lane_fifo_error, 2))
    else $error("lane event missing from flags");
  a_trim0_apply: assert property (reg_wr && reg_addr == 12'h330 |-> ##2
    core0_offset_value == $past(reg_wdata[11:0], 2))
    else $error("core 0 trim not applied");
  a_trim1_apply: assert property (reg_wr && reg_addr == 12'h332 |-> ##2
    core1_offset_value == $past(reg_wdata[11:0], 2))
    else $error("core 1 trim not applied");
  a_core2_first: assert property (reg_wr && reg_addr == 12'h334
    ##1 !core2_on_second_input [*3]
    |-> core2_offset_value == $past(reg_wdata[11:0], 3))
    else $error("core 2 first input trim not applied");
  a_core2_second: assert property (reg_wr && reg_addr == 12'h336
    ##1 core2_on_second_input [*3]
    |-> core2_offset_value == $past(reg_wdata[11:0], 3))
    else $error("core 2 second input trim not applied");
  // Fuse value must be on the core well after reset release
  a_fuse_load: assert property (!$past(rstn, 6) && $past(rstn, 5)
    |-> core0_offset_value == fuse_core0)
    else $error("fuse value not loaded");
  a_cal_enable: assert property (reg_wr && reg_addr == 12'h340 ##1 !reg_wr |-> ##1
    offset_calibration_enable == $past(reg_wdata[0], 2))
    else $error("offset calibration enable wrong");
  a_reset_quiet: assert property (!$past(rstn) |-> !irq && reg_rdata == 16'h0000)
    else $error("outputs active at reset release");
endmodule

bind lane_alarm_offset_trim_regs lane_alarm_offset_trim_regs_properties #(.LANES(LANES),
  .TRIM_W(TRIM_W)) i_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .lane_fifo_error(lane_fifo_error), .serial_link_enable(serial_link_enable),
  .fuse_core0(fuse_core0), .core2_on_second_input(core2_on_second_input),
  .core0_offset_value(core0_offset_value), .core1_offset_value(core1_offset_value),
  .core2_offset_value(core2_offset_value),
  .offset_calibration_enable(offset_calibration_enable), .irq(irq));

// ===== verilog/lane_alarm_bit.sv
// One sticky write-one-to-clear alarm flag with set priority
`timescale 1ns/10ps
module lane_alarm_bit #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Event and clear
  input wire logic set_evt,
  input wire logic clr,
  // Flag
  output logic flag_q
);

  logic flag_d;

  // A persisting event re-sets the flag in the same cycle as a clear
  assign flag_d = set_evt | (flag_q & ~clr);

  // Flag register, all alarms come out of reset set
  always_ff @(posedge clk)
  begin
    if (!rstn)
      flag_q <= RESET_VAL;
    else
      flag_q <= flag_d;
  end

endmodule

// ===== verilog/lane_alarm_offset_trim_regs.sv
// Lane FIFO alarm flags, summary alarm, interrupt and core offset trim registers
// What this block does
// RULE1 - Set lane flag bit i when lane i FIFO overflows or underflows.
// RULE2 - Writing one clears a lane flag; persisting condition sets it again at once.
// RULE3 - Writing one to the summary FIFO alarm clears all lane flags.
// RULE4 - Lane flags reset to all ones.
// RULE5 - Each trim register holds a 12-bit unsigned value driven to its core.
// RULE6 - Core 2 uses one trim per input, selected by the sampled input.
// RULE7 - Trim power-up contents come from factory fuse storage.
// RULE8 - Host writes zero into trim bits 15:12.
// RULE9 - Host avoids trim access while offset calibration runs.
// RULE10 - Foreground-only offset calibration: access trims after foreground done.
// RULE11 - Background plus continuous offset calibration: never access trims.
// RULE12 - Foreground step still calibrates spare cores with background, no continuous.
// RULE13 - Otherwise host may access trims at any time.
// RULE14 - Summary FIFO alarm bit 5 sets on any active lane error, W1C.
// RULE15 - All alarms set after reset; undefined while the link is disabled.
// RULE16 - Trims read back last write, applied to cores the cycle after.
`timescale 1ns/10ps
module lane_alarm_offset_trim_regs #(
  parameter int LANES = 8,
  parameter int TRIM_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Lane FIFO error pulses, on clk
  input wire logic [LANES-1:0] lane_fifo_error,
  input wire logic serial_link_enable,
  // Factory fuse values, static pins
  input wire logic [TRIM_W-1:0] fuse_core0,
  input wire logic [TRIM_W-1:0] fuse_core1,
  input wire logic [TRIM_W-1:0] fuse_core2_a,
  input wire logic [TRIM_W-1:0] fuse_core2_b,
  // Calibration engine status and core 2 input selection, on clk
  input wire logic offset_cal_busy,
  input wire logic foreground_complete_flag,
  input wire logic core2_on_second_input,
  // Trim outputs to the cores
  output logic [TRIM_W-1:0] core0_offset_value,
  output logic [TRIM_W-1:0] core1_offset_value,
  output logic [TRIM_W-1:0] core2_offset_value,
  // Calibration control to the engine
  output logic offset_calibration_enable,
  output logic background_calibration_enable,
  output logic continuous_background_offset_enable,
  // Interrupt
  output logic irq
);

  // Decoded strobes
  wire logic wr_lane = reg_wr && (reg_addr == trim_pkg::LANE_FIFO_ALARM_FLAGS_ADDR);
  wire logic wr_stat = reg_wr && (reg_addr == trim_pkg::ALARM_STATUS_ADDR);
  wire logic wr_mask = reg_wr && (reg_addr == trim_pkg::ALARM_MASK_ADDR);
  wire logic wr_ctl = reg_wr && (reg_addr == trim_pkg::CAL_CONTROL_ADDR);
  wire logic wr_trim0 = reg_wr && (reg_addr == trim_pkg::CORE0_OFFSET_TRIM_ADDR);
  wire logic wr_trim1 = reg_wr && (reg_addr == trim_pkg::CORE1_OFFSET_TRIM_ADDR);
  wire logic wr_trim2a = reg_wr && (reg_addr == trim_pkg::CORE2_INPUT_A_OFFSET_TRIM_ADDR);
  wire logic wr_trim2b = reg_wr && (reg_addr == trim_pkg::CORE2_INPUT_B_OFFSET_TRIM_ADDR);

  // Summary clear wipes every lane flag along with itself
  wire logic summary_clr = wr_stat && reg_wdata[trim_pkg::SUMMARY_FIFO_BIT]; // [RULE3]

  // Error events only count while the link runs; flags hold their value otherwise
  wire logic [LANES-1:0] lane_evt = lane_fifo_error & {LANES{serial_link_enable}}; // [RULE15]

  // Lane flags, reset to all ones
  logic [LANES-1:0] per_lane_overflow_flags;
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      lane_alarm_bit #(
        .RESET_VAL(trim_pkg::LANE_FLAGS_RESET[gi]) // [RULE4]
      ) u_bit (
        .clk(clk),
        .rstn(rstn),
        .set_evt(lane_evt[gi]), // [RULE1]
        .clr((wr_lane && reg_wdata[gi]) || summary_clr), // [RULE2] [RULE3]
        .flag_q(per_lane_overflow_flags[gi])
      );
    end
  endgenerate

  // Summary flag, set by any active lane error
  logic summary_lane_overflow_flag;
  lane_alarm_bit #(
    .RESET_VAL(trim_pkg::ALARM_STATUS_RESET[trim_pkg::SUMMARY_FIFO_BIT]) // [RULE15]
  ) u_summary (
    .clk(clk),
    .rstn(rstn),
    .set_evt(|lane_evt), // [RULE14]
    .clr(summary_clr), // [RULE14]
    .flag_q(summary_lane_overflow_flag)
  );

  // Fuse values are static straps; synchronise before use
  logic [4*TRIM_W-1:0] fuse_sync;
  sync2 #(
    .W(4*TRIM_W)
  ) u_fuse_sync (
    .clk(clk),
    .rstn(rstn),
    .din({fuse_core0, fuse_core1, fuse_core2_a, fuse_core2_b}),
    .dout(fuse_sync)
  );

  // Fuse load runs a few cycles after reset release so the synchroniser has settled
  logic [1:0] load_cnt_q;
  wire logic fuse_load_now = (load_cnt_q == trim_pkg::FUSE_LOAD_CYCLE);
  always_ff @(posedge clk)
  begin
    if (!rstn)
      load_cnt_q <= 2'h0;
    else if (load_cnt_q != trim_pkg::FUSE_CNT_LAST)
      load_cnt_q <= load_cnt_q + 2'h1;
  end

  // Trim registers; bits 15:12 are stored so software reads back what it wrote
  logic [15:0] trim0_q;
  logic [15:0] trim1_q;
  logic [15:0] trim2a_q;
  logic [15:0] trim2b_q;

  // Core 0 trim; the one-time fuse load beats a write in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
      trim0_q <= trim_pkg::READ_ZERO;
    else if (fuse_load_now)
      trim0_q <= {4'h0, fuse_sync[4*TRIM_W-1 -: TRIM_W]}; // [RULE7]
    else if (wr_trim0)
      trim0_q <= reg_wdata; // [RULE16]
  end

  // Core 1 trim
  always_ff @(posedge clk)
  begin
    if (!rstn)
      trim1_q <= trim_pkg::READ_ZERO;
    else if (fuse_load_now)
      trim1_q <= {4'h0, fuse_sync[3*TRIM_W-1 -: TRIM_W]}; // [RULE7]
    else if (wr_trim1)
      trim1_q <= reg_wdata; // [RULE16]
  end

  // Core 2 trim used while sampling the first input
  always_ff @(posedge clk)
  begin
    if (!rstn)
      trim2a_q <= trim_pkg::READ_ZERO;
    else if (fuse_load_now)
      trim2a_q <= {4'h0, fuse_sync[2*TRIM_W-1 -: TRIM_W]}; // [RULE7]
    else if (wr_trim2a)
      trim2a_q <= reg_wdata; // [RULE16]
  end

  // Core 2 trim used while sampling the second input
  always_ff @(posedge clk)
  begin
    if (!rstn)
      trim2b_q <= trim_pkg::READ_ZERO;
    else if (fuse_load_now)
      trim2b_q <= {4'h0, fuse_sync[TRIM_W-1 -: TRIM_W]}; // [RULE7]
    else if (wr_trim2b)
      trim2b_q <= reg_wdata; // [RULE16]
  end

  // Core 0 trim output, one cycle behind its register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      core0_offset_value <= '0;
    else
      core0_offset_value <= trim0_q[TRIM_W-1:0]; // [RULE5]
  end

  // Core 1 trim output
  always_ff @(posedge clk)
  begin
    if (!rstn)
      core1_offset_value <= '0;
    else
      core1_offset_value <= trim1_q[TRIM_W-1:0]; // [RULE5]
  end

  // Core 2 trim output follows the input it is sampling
  always_ff @(posedge clk)
  begin
    if (!rstn)
      core2_offset_value <= '0;
    else
      core2_offset_value <= core2_on_second_input ? trim2b_q[TRIM_W-1:0]
                                                  : trim2a_q[TRIM_W-1:0]; // [RULE6]
  end

  // Calibration control; the engine owns the spare-core step
  logic [3:0] cal_ctl_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cal_ctl_q <= trim_pkg::CAL_CONTROL_RESET;
    else if (wr_ctl)
      cal_ctl_q <= reg_wdata[3:0];
  end

  // Offset calibration enable to the engine
  always_ff @(posedge clk)
  begin
    if (!rstn)
      offset_calibration_enable <= 1'b0;
    else
      offset_calibration_enable <= cal_ctl_q[trim_pkg::OFFSET_CAL_EN_BIT]; // [RULE12]
  end

  // Background enable; with continuous off the engine still trims spares in foreground
  always_ff @(posedge clk)
  begin
    if (!rstn)
      background_calibration_enable <= 1'b0;
    else
      background_calibration_enable <= cal_ctl_q[trim_pkg::BG_CAL_EN_BIT]; // [RULE12]
  end

  // Continuous background offset enable
  always_ff @(posedge clk)
  begin
    if (!rstn)
      continuous_background_offset_enable <= 1'b0;
    else
      continuous_background_offset_enable <= cal_ctl_q[trim_pkg::CONT_BG_OFFSET_EN_BIT];
  end

  // Calibration engine status travels as one carrier inside the slice
  wire trim_pkg::cal_state_type cal_state = {offset_cal_busy, foreground_complete_flag};

  // Trim access is safe when no restricting calibration condition holds
  wire logic offset_cal_on = cal_ctl_q[trim_pkg::OFFSET_CAL_EN_BIT];
  wire logic bg_cal_on = cal_ctl_q[trim_pkg::BG_CAL_EN_BIT];
  wire logic cont_bg_on = cal_ctl_q[trim_pkg::CONT_BG_OFFSET_EN_BIT];
  wire logic access_ok = !cal_state.offset_cal_busy // [RULE9]
    && !(bg_cal_on && cont_bg_on) // [RULE11]
    && !(offset_cal_on && !cal_state.foreground_complete_flag); // [RULE10] [RULE13]

  // Alarm mask, same layout as the status register
  logic [7:0] alarm_mask_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
      alarm_mask_q <= trim_pkg::ALARM_MASK_RESET;
    else if (wr_mask)
      alarm_mask_q <= reg_wdata[7:0];
  end

  // Level interrupt while the summary alarm is set and unmasked
  always_ff @(posedge clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= summary_lane_overflow_flag && !alarm_mask_q[trim_pkg::SUMMARY_FIFO_BIT];
  end

  // Read mux; unmapped addresses read as zero
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = trim_pkg::READ_ZERO;
    unique case (reg_addr)
      trim_pkg::LANE_FIFO_ALARM_FLAGS_ADDR: rd_mux = {8'h00, per_lane_overflow_flags};
      trim_pkg::ALARM_STATUS_ADDR:
        rd_mux[trim_pkg::SUMMARY_FIFO_BIT] = summary_lane_overflow_flag;
      trim_pkg::ALARM_MASK_ADDR: rd_mux = {8'h00, alarm_mask_q};
      trim_pkg::CAL_CONTROL_ADDR: rd_mux = {12'h000, cal_ctl_q};
      trim_pkg::CAL_STATUS_ADDR:
      begin
        rd_mux[trim_pkg::FOREGROUND_DONE_BIT] = cal_state.foreground_complete_flag;
        rd_mux[trim_pkg::ACCESS_OK_BIT] = access_ok;
      end
      trim_pkg::CORE0_OFFSET_TRIM_ADDR: rd_mux = trim0_q; // [RULE16]
      trim_pkg::CORE1_OFFSET_TRIM_ADDR: rd_mux = trim1_q;
      trim_pkg::CORE2_INPUT_A_OFFSET_TRIM_ADDR: rd_mux = trim2a_q;
      trim_pkg::CORE2_INPUT_B_OFFSET_TRIM_ADDR: rd_mux = trim2b_q;
      default: rd_mux = trim_pkg::READ_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= trim_pkg::READ_ZERO;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= trim_pkg::READ_ZERO;
  end

endmodule

// ===== verilog/sync2.sv
// Two-flop synchroniser for a vector of slow levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// ===== verilog/trim_pkg.sv
// Shared constants and carrier types for the lane alarm and offset trim register slice
package trim_pkg;

  // Register port, lane count and trim widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int LANES = 8;
  localparam int TRIM_W = 12;

  // Register addresses (byte-addressed register port)
  localparam logic [11:0] LANE_FIFO_ALARM_FLAGS_ADDR = 12'h2C4;
  localparam logic [11:0] CORE0_OFFSET_TRIM_ADDR = 12'h330;
  localparam logic [11:0] CORE1_OFFSET_TRIM_ADDR = 12'h332;
  localparam logic [11:0] CORE2_INPUT_A_OFFSET_TRIM_ADDR = 12'h334;
  localparam logic [11:0] CORE2_INPUT_B_OFFSET_TRIM_ADDR = 12'h336;
  // Alarm status, mask, calibration control and calibration status registers of this slice
  localparam logic [11:0] ALARM_STATUS_ADDR = 12'h2C0;
  localparam logic [11:0] ALARM_MASK_ADDR = 12'h2C2;
  localparam logic [11:0] CAL_CONTROL_ADDR = 12'h340;
  localparam logic [11:0] CAL_STATUS_ADDR = 12'h342;

  // Field positions
  localparam int SUMMARY_FIFO_BIT = 5;
  localparam int OFFSET_CAL_EN_BIT = 0;
  localparam int BG_CAL_EN_BIT = 1;
  localparam int CONT_BG_OFFSET_EN_BIT = 2;
  localparam int CAL_INPUT_SEL_BIT = 3;
  localparam int FOREGROUND_DONE_BIT = 0;
  localparam int ACCESS_OK_BIT = 1;

  // Cycle counts after reset release
  localparam logic [1:0] FUSE_LOAD_CYCLE = 2'h2;
  localparam logic [1:0] FUSE_CNT_LAST = 2'h3;

  // Reset values
  localparam logic [7:0] LANE_FLAGS_RESET = 8'hFF;
  localparam logic [7:0] ALARM_STATUS_RESET = 8'h20;
  localparam logic [7:0] ALARM_MASK_RESET = 8'h20;
  localparam logic [3:0] CAL_CONTROL_RESET = 4'h0;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Calibration engine status, as seen by this slice
  typedef struct packed {
    logic offset_cal_busy;
    logic foreground_complete_flag;
  } cal_state_type;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage
